// ===== hdl/snf_front_end.v
// Serial NAND command front end: SPI link, opcode decode, cache access
`timescale 1ns/1ps
`default_nettype none

`include "snf_defines.vh"

module snf_front_end
(
  input  wire                  core_clk,
  input  wire                  rst_n,
  input  wire                  cs_n_pin,
  input  wire                  sck_pin,
  input  wire [3:0]            io_in,
  output reg  [3:0]            io_out,
  output reg  [3:0]            io_oe_n,
  input  wire [7:0]            status_in,
  output reg                   write_latch_flag,
  output reg                   op_start,
  output reg  [7:0]            op_code,
  output reg  [`SNF_ROW_W-1:0] op_row,
  output reg                   plane_select_row_bit,
  output reg                   abort_pulse,
  input  wire                  arr_wr_en,
  input  wire [`SNF_COL_W-1:0] arr_wr_addr,
  input  wire [7:0]            arr_wr_data
);

  // ****************************************
  // States and kinds
  // ****************************************
  localparam S_IDLE  = 3'h0;
  localparam S_ADDR  = 3'h1;
  localparam S_DUMMY = 3'h2;
  localparam S_DATA  = 3'h3;
  localparam S_DONE  = 3'h4;
  localparam S_IGN   = 3'h5;

  localparam K_NONE  = 2'h0;
  localparam K_RD    = 2'h1;
  localparam K_WR    = 2'h2;
  localparam K_FEAT  = 2'h3;

  // ****************************************
  // Input synchronisers
  // ****************************************
  reg        cs_s1_ff;
  reg        cs_s2_ff;
  reg        cs_d_ff;
  reg        sck_s1_ff;
  reg        sck_s2_ff;
  reg        sck_d_ff;
  reg  [3:0] io_s1_ff;
  reg  [3:0] io_s2_ff;

  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cs_s1_ff  <= 1'b1;
      cs_s2_ff  <= 1'b1;
      cs_d_ff   <= 1'b1;
      sck_s1_ff <= 1'b0;
      sck_s2_ff <= 1'b0;
      sck_d_ff  <= 1'b0;
      io_s1_ff  <= 4'h0;
      io_s2_ff  <= 4'h0;
    end
    else
    begin
      cs_s1_ff  <= cs_n_pin;
      cs_s2_ff  <= cs_s1_ff;
      cs_d_ff   <= cs_s2_ff;
      sck_s1_ff <= sck_pin;
      sck_s2_ff <= sck_s1_ff;
      sck_d_ff  <= sck_s2_ff;
      io_s1_ff  <= io_in;
      io_s2_ff  <= io_s1_ff;
    end
  end

  // Edges count only while selected, so an idle clock level of either mode is harmless
  wire sck_rise = sck_s2_ff & ~sck_d_ff & ~cs_s2_ff;
  wire sck_fall = ~sck_s2_ff & sck_d_ff & ~cs_s2_ff;
  wire cs_rise  = cs_s2_ff & ~cs_d_ff;

  // ****************************************
  // Command state
  // ****************************************
  reg  [2:0]            st_ff;
  reg  [7:0]            opc_ff;
  reg  [1:0]            kind_ff;
  reg  [1:0]            cnt_ff;
  reg  [1:0]            dum_ff;
  reg  [2:0]            aw_ff;
  reg  [2:0]            dw_ff;
  reg  [2:0]            bcnt_ff;
  reg  [7:0]            sh_ff;
  reg  [23:0]           addr_ff;
  reg  [`SNF_COL_W-1:0] col_ff;
  reg  [2:0]            ocnt_ff;
  reg  [7:0]            osh_ff;
  wire [7:0]            rd_data;

  // Active width: opcode always single line, then address or data width
  wire [2:0] cur_w = (st_ff == S_IDLE) ? 3'h1 : (st_ff == S_DATA) ? dw_ff : aw_ff;
  wire [3:0] bsum  = {1'b0, bcnt_ff} + {1'b0, cur_w};
  wire       bdone = sck_rise & bsum[3];

  reg [7:0] in_byte;
  always @*
  begin
    case (cur_w)
      3'h2:    in_byte = {sh_ff[5:0], io_s2_ff[1:0]};
      3'h4:    in_byte = {sh_ff[3:0], io_s2_ff[3:0]};
      default: in_byte = {sh_ff[6:0], io_s2_ff[0]};
    endcase
  end

  // ****************************************
  // Opcode decode
  // ****************************************
  reg       dec_ok;
  reg [1:0] dec_an;
  reg [1:0] dec_dn;
  reg [2:0] dec_aw;
  reg [2:0] dec_dw;
  reg [1:0] dec_kind;

  always @*
  begin
    dec_ok   = 1'b1;
    dec_an   = 2'h2;
    dec_dn   = 2'h1;
    dec_aw   = 3'h1;
    dec_dw   = 3'h1;
    dec_kind = K_RD;
    case (in_byte)
      `SNF_OP_RD_X1, `SNF_OP_RD_X1_FAST: dec_dw = 3'h1;
      `SNF_OP_RD_X2:   dec_dw = 3'h2;
      `SNF_OP_RD_X4:   dec_dw = 3'h4;
      `SNF_OP_RD_DUAL:
      begin
        dec_aw = 3'h2;
        dec_dw = 3'h2;
      end
      `SNF_OP_RD_QUAD:
      begin
        dec_aw = 3'h4;
        dec_dw = 3'h4;
        dec_dn = 2'h2;
      end
      `SNF_OP_LOAD_X1, `SNF_OP_LOAD_RND1:
      begin
        dec_kind = K_WR;
        dec_dn   = 2'h0;
      end
      `SNF_OP_LOAD_X4, `SNF_OP_LOAD_RND4:
      begin
        dec_kind = K_WR;
        dec_dn   = 2'h0;
        dec_dw   = 3'h4;
      end
      `SNF_OP_GET_FEAT:
      begin
        dec_kind = K_FEAT;
        dec_an   = 2'h1;
        dec_dn   = 2'h0;
      end
      `SNF_OP_PAGE_READ, `SNF_OP_CACHE_RND, `SNF_OP_ERASE, `SNF_OP_PROG_EXEC,
      `SNF_OP_PERM_LOCK:
      begin
        dec_kind = K_NONE;
        dec_an   = 2'h3;
        dec_dn   = 2'h0;
      end
      `SNF_OP_WR_EN, `SNF_OP_WR_DIS, `SNF_OP_RESET, `SNF_OP_CACHE_LAST:
      begin
        dec_kind = K_NONE;
        dec_an   = 2'h0;
        dec_dn   = 2'h0;
      end
      default: dec_ok = 1'b0;
    endcase
  end

  // ****************************************
  // Output byte source
  // ****************************************
  wire       col_oob  = (col_ff >= `SNF_PAGE_BYTES);
  wire [7:0] stat_val = {status_in[7:2], write_latch_flag, status_in[0]};
  wire [7:0] cur_byte = (ocnt_ff != 3'h0) ? osh_ff :
                        (kind_ff == K_FEAT) ? stat_val :
                        col_oob ? `SNF_OOB_DATA : rd_data;

  reg [3:0] nxt_io_out;
  reg [3:0] nxt_oe_n;
  reg [7:0] nxt_osh;
  always @*
  begin
    case (dw_ff)
      3'h2:
      begin
        nxt_io_out = {2'h0, cur_byte[7:6]};
        nxt_oe_n   = `SNF_OE_X2;
        nxt_osh    = {cur_byte[5:0], 2'h0};
      end
      3'h4:
      begin
        nxt_io_out = cur_byte[7:4];
        nxt_oe_n   = `SNF_OE_X4;
        nxt_osh    = {cur_byte[3:0], 4'h0};
      end
      default:
      begin
        nxt_io_out = {2'h0, cur_byte[7], 1'b0};
        nxt_oe_n   = `SNF_OE_X1;
        nxt_osh    = {cur_byte[6:0], 1'b0};
      end
    endcase
  end

  wire rd_phase = (st_ff == S_DATA) && (kind_ff != K_WR);
  wire wr_spi   = bdone && (st_ff == S_DATA) && (kind_ff == K_WR) && !col_oob;
  wire [`SNF_COL_W-1:0] ram_wa = wr_spi ? col_ff : arr_wr_addr;
  wire [7:0]            ram_wd = wr_spi ? in_byte : arr_wr_data;

  // ****************************************
  // Link sequencer
  // ****************************************
  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_ff   <= S_IDLE;
      opc_ff  <= 8'h00;
      kind_ff <= K_NONE;
      cnt_ff  <= 2'h0;
      dum_ff  <= 2'h0;
      aw_ff   <= 3'h1;
      dw_ff   <= 3'h1;
      bcnt_ff <= 3'h0;
      sh_ff   <= 8'h00;
      addr_ff <= 24'h000000;
      col_ff  <= {`SNF_COL_W{1'b0}};
      ocnt_ff <= 3'h0;
      osh_ff  <= 8'h00;
      io_out  <= 4'h0;
      io_oe_n <= `SNF_OE_OFF;
    end
    else if (cs_s2_ff)
    begin
      st_ff   <= S_IDLE;
      bcnt_ff <= 3'h0;
      ocnt_ff <= 3'h0;
      io_oe_n <= `SNF_OE_OFF;
    end
    else
    begin
      if (sck_rise)
      begin
        bcnt_ff <= bsum[2:0];
        sh_ff   <= in_byte;
      end
      if (bdone)
      begin
        case (st_ff)
          S_IDLE:
          begin
            opc_ff  <= in_byte;
            kind_ff <= dec_kind;
            cnt_ff  <= dec_an;
            dum_ff  <= dec_dn;
            aw_ff   <= dec_aw;
            dw_ff   <= dec_dw;
            if (!dec_ok)
              st_ff <= S_IGN;
            else if (dec_an != 2'h0)
              st_ff <= S_ADDR;
            else
              st_ff <= S_DONE;
          end
          S_ADDR:
          begin
            addr_ff <= {addr_ff[15:0], in_byte};
            col_ff  <= {addr_ff[3:0], in_byte};
            cnt_ff  <= cnt_ff - 2'h1;
            if (cnt_ff == 2'h1)
            begin
              if (dum_ff != 2'h0)
                st_ff <= S_DUMMY;
              else if (kind_ff != K_NONE)
                st_ff <= S_DATA;
              else
                st_ff <= S_DONE;
            end
          end
          S_DUMMY:
          begin
            dum_ff <= dum_ff - 2'h1;
            if (dum_ff == 2'h1)
              st_ff <= S_DATA;
          end
          S_DATA:
          begin
            if (kind_ff == K_WR && !col_oob)
              col_ff <= col_ff + 12'h001;
          end
          default: st_ff <= st_ff;
        endcase
      end
      if (sck_fall && rd_phase)
      begin
        io_out  <= nxt_io_out;
        io_oe_n <= nxt_oe_n;
        osh_ff  <= nxt_osh;
        ocnt_ff <= ocnt_ff + dw_ff;
        if (ocnt_ff == 3'h0 && kind_ff == K_RD && !col_oob)
          col_ff <= col_ff + 12'h001;
      end
    end
  end

  // ****************************************
  // Command execution at deselect
  // ****************************************
  wire done_ok = cs_rise && (st_ff == S_DONE);

  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      write_latch_flag     <= `SNF_LATCH_RST;
      op_start             <= 1'b0;
      op_code              <= 8'h00;
      op_row               <= {`SNF_ROW_W{1'b0}};
      plane_select_row_bit <= 1'b0;
      abort_pulse          <= 1'b0;
    end
    else
    begin
      op_start    <= 1'b0;
      abort_pulse <= 1'b0;
      if (done_ok)
      begin
        case (opc_ff)
          `SNF_OP_WR_EN:  write_latch_flag <= 1'b1;
          `SNF_OP_WR_DIS: write_latch_flag <= 1'b0;
          `SNF_OP_RESET:
          begin
            write_latch_flag <= 1'b0;
            abort_pulse      <= 1'b1;
          end
          `SNF_OP_ERASE, `SNF_OP_PROG_EXEC:
          begin
            op_start <= write_latch_flag;
          end
          default: op_start <= 1'b1;
        endcase
        op_code              <= opc_ff;
        op_row               <= addr_ff[`SNF_ROW_W-1:0];
        plane_select_row_bit <= addr_ff[`SNF_PLANE_BIT];
      end
    end
  end

  // ****************************************
  // Cache storage
  // ****************************************
  snf_cache_ram u_cache
  (
    .core_clk (core_clk),
    .wr_en    (wr_spi | arr_wr_en),
    .wr_addr  (ram_wa),
    .wr_data  (ram_wd),
    .rd_addr  (col_ff),
    .rd_data  (rd_data)
  );

endmodule

`default_nettype wire

// ===== hdl/snf_defines.vh
// Constants of the serial NAND command front end
`ifndef SNF_DEFINES_VH
`define SNF_DEFINES_VH

// ****************************************
// Opcodes
// ****************************************
`define SNF_OP_RESET      8'hFF
`define SNF_OP_GET_FEAT   8'h0F
`define SNF_OP_PAGE_READ  8'h13
`define SNF_OP_CACHE_RND  8'h30
`define SNF_OP_CACHE_LAST 8'h3F
`define SNF_OP_RD_X1      8'h03
`define SNF_OP_RD_X1_FAST 8'h0B
`define SNF_OP_RD_X2      8'h3B
`define SNF_OP_RD_X4      8'h6B
`define SNF_OP_RD_DUAL    8'hBB
`define SNF_OP_RD_QUAD    8'hEB
`define SNF_OP_WR_EN      8'h06
`define SNF_OP_WR_DIS     8'h04
`define SNF_OP_ERASE      8'hD8
`define SNF_OP_PROG_EXEC  8'h10
`define SNF_OP_LOAD_X1    8'h02
`define SNF_OP_LOAD_X4    8'h32
`define SNF_OP_LOAD_RND1  8'h84
`define SNF_OP_LOAD_RND4  8'h34
`define SNF_OP_PERM_LOCK  8'h2C

// ****************************************
// Page and address layout
// ****************************************
`define SNF_COL_W         12
`define SNF_PAGE_BYTES    12'h880
`define SNF_ROW_W         17
`define SNF_PLANE_BIT     6
`define SNF_LATCH_BIT     1

// ****************************************
// Reset values and pin patterns
// ****************************************
`define SNF_LATCH_RST     1'b0
`define SNF_OE_OFF        4'hF
`define SNF_OE_X1         4'hD
`define SNF_OE_X2         4'hC
`define SNF_OE_X4         4'h0
`define SNF_OOB_DATA      8'hFF

`endif

// ===== hdl/snf_cache_ram.v
// Cache register storage with registered read data
`timescale 1ns/1ps
`default_nettype none

`include "snf_defines.vh"

module snf_cache_ram
(
  input  wire                  core_clk,
  input  wire                  wr_en,
  input  wire [`SNF_COL_W-1:0] wr_addr,
  input  wire [7:0]            wr_data,
  input  wire [`SNF_COL_W-1:0] rd_addr,
  output reg  [7:0]            rd_data
);

  reg [7:0] mem [0:`SNF_PAGE_BYTES-1];

  always @(posedge core_clk)
  begin
    if (wr_en)
    begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end

endmodule

`default_nettype wire

// ===== sim/snf_monitor.sv
// Port checks of the serial NAND command front end
`timescale 1ns/1ps
`default_nettype none
`include "snf_defines.vh"
module snf_monitor
(
  input wire logic                  core_clk,
  input wire logic                  rst_n,
  input wire logic                  cs_n_pin,
  input wire logic                  sck_pin,
  input wire logic [3:0]            io_in,
  input wire logic [3:0]            io_out,
  input wire logic [3:0]            io_oe_n,
  input wire logic [7:0]            status_in,
  input wire logic                  write_latch_flag,
  input wire logic                  op_start,
  input wire logic [7:0]            op_code,
  input wire logic [`SNF_ROW_W-1:0] op_row,
  input wire logic                  plane_select_row_bit,
  input wire logic                  abort_pulse,
  input wire logic                  arr_wr_en,
  input wire logic [`SNF_COL_W-1:0] arr_wr_addr,
  input wire logic [7:0]            arr_wr_data
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  sequence s_idle;
    cs_n_pin [*6];
  endsequence
  sequence s_high;
    (!cs_n_pin && sck_pin) [*3];
  endsequence
  sequence s_prog;
    op_start ##1 (op_code == 8'h10 || op_code == 8'hD8);
  endsequence
  property p_idle_off;
    s_idle |-> io_oe_n == 4'hF;
  endproperty
  property p_oe_pat;
    io_oe_n inside {4'hF, 4'hD, 4'hC, 4'h0};
  endproperty
  property p_out_hold;
    s_high |-> $stable(io_out);
  endproperty
  property p_start_once;
    op_start |=> !op_start;
  endproperty
  property p_start_cs;
    op_start |-> cs_n_pin && $past(cs_n_pin, 2);
  endproperty
  property p_plane;
    op_start |=> plane_select_row_bit == op_row[6];
  endproperty
  property p_prog_gate;
    s_prog |-> write_latch_flag;
  endproperty
  property p_flag_cs;
    $changed(write_latch_flag) |-> cs_n_pin;
  endproperty
  property p_abort;
    abort_pulse |=> !abort_pulse && !write_latch_flag;
  endproperty
  a_idle_off: assert property (p_idle_off) else $error("Lines driven while idle");
  a_oe_pat: assert property (p_oe_pat) else $error("Bad enable pattern");
  a_out_hold: assert property (p_out_hold) else $error("Output moved while clock high");
  a_start_once: assert property (p_start_once) else $error("Start pulse too long");
  a_start_cs: assert property (p_start_cs) else $error("Start while selected");
  a_plane: assert property (p_plane) else $error("Plane bit mismatch");
  a_prog_gate: assert property (p_prog_gate) else $error("Array change without flag");
  a_flag_cs: assert property (p_flag_cs) else $error("Flag moved in frame");
  a_abort: assert property (p_abort) else $error("Abort did not clear flag");
endmodule
bind snf_front_end snf_monitor mon
(
  .core_clk(core_clk), .rst_n(rst_n), .cs_n_pin(cs_n_pin), .sck_pin(sck_pin),
  .io_in(io_in), .io_out(io_out), .io_oe_n(io_oe_n), .status_in(status_in),
  .write_latch_flag(write_latch_flag), .op_start(op_start), .op_code(op_code),
  .op_row(op_row), .plane_select_row_bit(plane_select_row_bit), .abort_pulse(abort_pulse),
  .arr_wr_en(arr_wr_en), .arr_wr_addr(arr_wr_addr), .arr_wr_data(arr_wr_data)
);
`default_nettype wire

// ===== sim/snf_host_model.sv
// SPI host controller model for the serial NAND front end
`timescale 1ns/1ps
`default_nettype none
module snf_host_model
(
  input  wire logic       core_clk,
  input  wire logic [3:0] io_w,
  output var  logic       cs_n,
  output var  logic       sck,
  output var  logic [3:0] io_h
);
  logic       mode3 = 1'b0;
  int         hp = 4;
  logic [7:0] tx [0:3];
  logic [7:0] rx [0:3];
  initial
  begin
    cs_n = 1'b1;
    sck = 1'b0;
    io_h = 4'h0;
  end
  task automatic set_mode(input logic m);
    @(negedge core_clk);
    mode3 = m;
    sck = m;
  endtask
  task automatic xb(input logic [7:0] d, input int w, input logic rd, output logic [7:0] q);
    logic [7:0] v;
    v = d;
    q = 8'h00;
    for (int i = 0; i < 8; i += w)
    begin
      @(negedge core_clk);
      sck = 1'b0;
      if (rd)
        io_h = ~io_h;
      else if (w == 1)
        io_h[0] = v[7];
      else if (w == 2)
        io_h[1:0] = v[7:6];
      else
        io_h = v[7:4];
      v = v << w;
      repeat (hp) @(negedge core_clk);
      sck = 1'b1;
      repeat (hp) @(negedge core_clk);
      q = (w == 1) ? {q[6:0], io_w[1]} : (w == 2) ? {q[5:0], io_w[1:0]} : {q[3:0], io_w};
    end
  endtask
  task automatic cmd(input logic [7:0] op, input int na, input logic [23:0] a, input int aw,
                     input int nd, input int nb, input int w, input logic rd);
    logic [7:0] q;
    @(negedge core_clk);
    cs_n = 1'b0;
    repeat (hp) @(negedge core_clk);
    xb(op, 1, 1'b0, q);
    for (int i = na - 1; i >= 0; i--)
      xb(a[8*i +: 8], aw, 1'b0, q);
    for (int i = 0; i < nd; i++)
      xb(8'h00, aw, 1'b0, q);
    for (int i = 0; i < nb; i++)
    begin
      xb(tx[i], w, rd, q);
      rx[i] = q;
    end
    @(negedge core_clk);
    sck = mode3;
    repeat (hp) @(negedge core_clk);
    cs_n = 1'b1;
    repeat (12) @(negedge core_clk);
  endtask
endmodule
`default_nettype wire

// ===== sim/tb.sv
// Self-checking testbench of the serial NAND command front end
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        core_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [7:0]  status_in = 8'h5C;
  logic        arr_wr_en = 1'b0;
  logic [11:0] arr_wr_addr = 12'h000;
  logic [7:0]  arr_wr_data = 8'h00;
  wire         cs_n_pin, sck_pin, write_latch_flag, op_start, plane_select_row_bit, abort_pulse;
  wire [3:0]   io_w, io_h, io_out, io_oe_n;
  wire [7:0]   op_code;
  wire [16:0]  op_row;
  int          error_cnt = 0;
  int          comparisons = 0;
  int          n_start = 0;
  int          n_abort = 0;
  int          n_drive = 0;
  logic [7:0]  ops [0:3] = '{8'h13, 8'h30, 8'h2C, 8'h3F};
  assign io_w = (io_out & ~io_oe_n) | (io_h & io_oe_n);
  always #50 core_clk = ~core_clk;
  always @(posedge core_clk)
  begin
    if (op_start === 1'b1) n_start++;
    if (abort_pulse === 1'b1) n_abort++;
    if (io_oe_n !== 4'hF) n_drive++;
  end
  snf_host_model host (.core_clk(core_clk), .io_w(io_w), .cs_n(cs_n_pin), .sck(sck_pin),
                       .io_h(io_h));
  snf_front_end dut (.core_clk(core_clk), .rst_n(rst_n), .cs_n_pin(cs_n_pin),
    .sck_pin(sck_pin), .io_in(io_w), .io_out(io_out), .io_oe_n(io_oe_n),
    .status_in(status_in), .write_latch_flag(write_latch_flag), .op_start(op_start),
    .op_code(op_code), .op_row(op_row), .plane_select_row_bit(plane_select_row_bit),
    .abort_pulse(abort_pulse), .arr_wr_en(arr_wr_en), .arr_wr_addr(arr_wr_addr),
    .arr_wr_data(arr_wr_data));
  task end_sim();
    $display("Mismatches %0d, comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task rd_chk(input logic [7:0] op, input logic [23:0] a, input int aw, input int nd,
              input int w);
    host.cmd(op, 2, a, aw, nd, 4, w, 1'b1);
    for (int i = 0; i < 4; i++)
      chk(host.rx[i], host.tx[i]);
  endtask
  task t_latch();
    chk(io_oe_n, 4'hF);
    host.cmd(8'h06, 0, 24'h0, 1, 0, 0, 1, 1'b0);
    chk(write_latch_flag, 1);
    host.cmd(8'h0F, 1, 24'hC0, 1, 0, 1, 1, 1'b1);
    chk(host.rx[0], 8'h5E);
    host.cmd(8'h04, 0, 24'h0, 1, 0, 0, 1, 1'b0);
    chk(write_latch_flag, 0);
    host.cmd(8'h10, 3, 24'h000040, 1, 0, 0, 1, 1'b0);
    chk(n_start, 0);
    host.cmd(8'h0F, 1, 24'hC0, 1, 0, 1, 1, 1'b1);
    chk(host.rx[0], 8'h5C);
  endtask
  task t_load();
    host.tx = '{8'hA5, 8'h3C, 8'hC3, 8'h5A};
    host.cmd(8'h02, 2, 24'h000020, 1, 0, 4, 1, 1'b0);
    host.set_mode(1'b1);
    rd_chk(8'h03, 24'h000020, 1, 1, 1);
    host.set_mode(1'b0);
    rd_chk(8'h0B, 24'h000020, 1, 1, 1);
    host.cmd(8'h32, 2, 24'h000040, 1, 0, 4, 4, 1'b0);
    rd_chk(8'h6B, 24'h000040, 1, 1, 4);
    rd_chk(8'h3B, 24'h000040, 1, 1, 2);
    rd_chk(8'hBB, 24'h000040, 2, 1, 2);
    rd_chk(8'hEB, 24'h000040, 4, 2, 4);
    host.tx[1] = 8'hE7;
    host.cmd(8'h84, 2, 24'h000020, 1, 0, 2, 1, 1'b0);
    rd_chk(8'h03, 24'h000020, 1, 1, 1);
    host.tx[2] = 8'h96;
    host.cmd(8'h34, 2, 24'h000040, 1, 0, 3, 4, 1'b0);
    rd_chk(8'h6B, 24'h000040, 1, 1, 4);
  endtask
  task t_bounds();
    @(negedge core_clk);
    arr_wr_addr = 12'h87E;
    arr_wr_data = 8'h99;
    arr_wr_en = 1'b1;
    @(negedge core_clk);
    arr_wr_en = 1'b0;
    host.tx = '{8'h11, 8'h22, 8'h00, 8'h00};
    host.cmd(8'h84, 2, 24'h00087F, 1, 0, 2, 1, 1'b0);
    host.tx = '{8'h99, 8'h11, 8'hFF, 8'hFF};
    rd_chk(8'h03, 24'h00087E, 1, 1, 1);
  endtask
  task t_ops();
    host.hp = 7;
    host.cmd(8'h06, 0, 24'h0, 1, 0, 0, 1, 1'b0);
    host.cmd(8'h10, 3, 24'h000147, 1, 0, 0, 1, 1'b0);
    chk(n_start, 1);
    chk({op_code, op_row, plane_select_row_bit}, {8'h10, 17'h00147, 1'b1});
    host.cmd(8'hD8, 3, 24'h000107, 1, 0, 0, 1, 1'b0);
    chk({n_start[7:0], op_code, plane_select_row_bit}, {8'h02, 8'hD8, 1'b0});
    host.hp = 4;
    for (int i = 0; i < 4; i++)
    begin
      host.cmd(ops[i], (i == 3) ? 0 : 3, 24'h000040, 1, 0, 0, 1, 1'b0);
      chk({n_start[7:0], op_code}, {i[7:0] + 8'h03, ops[i]});
    end
    host.cmd(8'h13, 1, 24'h000001, 1, 0, 0, 1, 1'b0);
    chk(n_start, 6);
    host.cmd(8'hFF, 0, 24'h0, 1, 0, 0, 1, 1'b0);
    chk({n_abort[7:0], write_latch_flag}, {8'h01, 1'b0});
  endtask
  task t_unsup();
    int base;
    base = n_drive;
    host.cmd(8'h9F, 0, 24'h0, 1, 1, 2, 1, 1'b1);
    chk(n_drive - base, 0);
  endtask
  initial
  begin
    #5_000_000;
    error_cnt++;
    end_sim();
  end
  initial
  begin
    repeat (10) @(negedge core_clk);
    rst_n = 1'b1;
    repeat (5) @(negedge core_clk);
    t_latch();
    t_load();
    t_bounds();
    t_ops();
    t_unsup();
    end_sim();
  end
endmodule
`default_nettype wire
